// File: core/pps_pkg.sv
// constants shared by the parallel slave port block
package pps_pkg;
    // ---------------------------------------------------------------
    // bus widths
    // ---------------------------------------------------------------
    localparam int PPS_AW = 8;
    localparam int PPS_DW = 32;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] PPS_OFF_PIN_EN = 8'h00;
    localparam logic [7:0] PPS_OFF_STATUS = 8'h04;
    localparam logic [7:0] PPS_OFF_PADCFG = 8'h08;
    localparam logic [7:0] PPS_OFF_CTRL   = 8'h0C;
    localparam logic [7:0] PPS_OFF_IN1    = 8'h10;
    localparam logic [7:0] PPS_OFF_IN2    = 8'h14;
    localparam logic [7:0] PPS_OFF_OUT1   = 8'h18;
    localparam logic [7:0] PPS_OFF_OUT2   = 8'h1C;

    // ---------------------------------------------------------------
    // writable bit masks
    // ---------------------------------------------------------------
    localparam logic [15:0] PPS_PIN_EN_MASK = 16'h47FF;
    localparam logic [15:0] PPS_PADCFG_MASK = 16'h0003;
    localparam logic [15:0] PPS_CTRL_MASK   = 16'h7B00;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int PPS_PIN_CS      = 14;
    localparam int PPS_PIN_ADDR    = 2;
    localparam int PPS_ST_IN_ALL   = 15;
    localparam int PPS_ST_IN_OVF   = 14;
    localparam int PPS_ST_OUT_ALL  = 7;
    localparam int PPS_ST_OUT_UNF  = 6;
    localparam int PPS_PAD_TTL     = 0;
    localparam int PPS_PAD_SEC     = 1;
    localparam int PPS_CTRL_MODE   = 8;
    localparam int PPS_CTRL_INC    = 11;
    localparam int PPS_CTRL_IRQ    = 13;

    // ---------------------------------------------------------------
    // reset values and encodings
    // ---------------------------------------------------------------
    localparam logic [15:0] PPS_REG_RESET   = 16'h0000;
    localparam logic [3:0]  PPS_EMPTY_RESET = 4'hF;
    localparam logic [1:0]  PPS_MODE_LEGACY = 2'h0;
    localparam logic [1:0]  PPS_MODE_ENH    = 2'h1;
    localparam logic [1:0]  PPS_INC_AUTO    = 2'h3;
    localparam logic [1:0]  PPS_IRQ_BUF3    = 2'h3;
    localparam logic [1:0]  PPS_SLOT_LAST   = 2'h3;
endpackage

// File: core/pps_slave_port.sv
// parallel slave port: pin enables, byte buffers, status, apb slave
//
// Notes on behaviour
// RULE_01: chip-select pad serves the port only while its pin enable is set.
// RULE_02: nine address pin enables hand upper address pads to the port.
// RULE_03: two low pin enables hand low address or latch pads to port.
// RULE_04: input-all-full reads one only when all four input bytes hold data.
// RULE_05: external write to a full input byte sets overflow; software clears.
// RULE_06: per-byte input full flag sets on write, clears on software read.
// RULE_07: output-all-empty reads one only when all four output bytes are empty.
// RULE_08: external read of an empty output byte sets underflow; software clears.
// RULE_09: per-byte output empty flag clears on software write, sets on read.
// RULE_10: after reset output empty flags read one, other status zero.
// RULE_11: addressable mode picks byte buffer from the two low address lines.
// RULE_12: input buffer select picks ttl levels when set, schmitt when clear.
// RULE_13: calendar pad carries seconds clock or alarm, gated by its enable.
// RULE_14: small package variant has no upper address pads to enable.
// RULE_15: unimplemented bits ignore writes and read zero.
// RULE_16: mode 01 is enhanced addressed slave, 00 legacy without address.
// RULE_17: irq mode 11 pulses on buffer 3 or address 11 access.
// RULE_18: increment mode 11 in legacy mode walks buffers on each transfer.
// RULE_19: the external master checks status before risking over or underflow.
// RULE_20: overflowing write keeps the old byte and only sets overflow.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module pps_slave_port #(
    parameter bit HAS_UPPER_ADDR = 1'b1
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [pps_pkg::PPS_AW-1:0] paddr,
    input  wire logic [pps_pkg::PPS_DW-1:0] pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [pps_pkg::PPS_DW-1:0]     prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      ext_cs,
    input  wire logic                      ext_rd,
    input  wire logic                      ext_wr,
    input  wire logic [1:0]                port_addr_low,
    input  wire logic [7:0]                ext_din,
    output logic [7:0]                     ext_dout,
    output logic                           ext_dout_oe,
    output logic                           buffer_irq,
    input  wire logic                      seconds_clock,
    input  wire logic                      alarm_pulse,
    input  wire logic                      calendar_out_enable,
    output logic                           calendar_pad,
    output logic                           ttl_input_select,
    output logic                           chip_select_pin_enable,
    output logic [8:0]                     address_pin_enables,
    output logic [1:0]                     latch_strobe_pin_enables
);
    import pps_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // masked byte-lane write; masked bits stay zero forever
    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st,
                                         input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (st[0]) begin
            v[7:0] = wd[7:0];
        end
        if (st[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & mask;
    endfunction

    // byte buffer chosen for an external transfer
    function automatic logic [1:0] slot_sel(input logic [1:0] md,
                                            input logic       inc,
                                            input logic [1:0] adr,
                                            input logic [1:0] ptr);
        logic [1:0] s;
        s = 2'h0;
        if (md == PPS_MODE_ENH) begin
            s = adr;
        end else if (inc) begin
            s = ptr;
        end
        return s;
    endfunction

    function automatic logic [3:0] slot_hot(input logic [1:0] s);
        return 4'(4'h1 << s);
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [15:0] pin_en;
    logic [15:0] pad_cfg;
    logic [15:0] ctrl;
    logic        in_ovf;
    logic        out_unf;
    logic [3:0]  in_full;
    logic [3:0]  out_empty;
    logic [7:0]  in_buf  [4];
    logic [7:0]  out_buf [4];
    logic [1:0]  rd_ptr;
    logic [1:0]  wr_ptr;
    logic        rd_q;
    logic        wr_q;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    wire apb_acc  = psel & penable & ~pready;
    wire apb_go   = psel & penable & pready;
    wire apb_wr   = apb_go & pwrite;
    wire apb_rd   = apb_go & ~pwrite;
    wire hit_pin  = paddr == PPS_OFF_PIN_EN;
    wire hit_st   = paddr == PPS_OFF_STATUS;
    wire hit_pad  = paddr == PPS_OFF_PADCFG;
    wire hit_ctrl = paddr == PPS_OFF_CTRL;
    wire hit_in1  = paddr == PPS_OFF_IN1;
    wire hit_in2  = paddr == PPS_OFF_IN2;
    wire hit_out1 = paddr == PPS_OFF_OUT1;
    wire hit_out2 = paddr == PPS_OFF_OUT2;
    wire mapped   = |{hit_pin, hit_st, hit_pad, hit_ctrl,
                      hit_in1, hit_in2, hit_out1, hit_out2};

    // ---------------------------------------------------------------
    // mode decode and external strobes
    // ---------------------------------------------------------------
    wire [1:0] mode     = ctrl[PPS_CTRL_MODE +: 2];
    wire [1:0] inc_mode = ctrl[PPS_CTRL_INC +: 2];
    wire [1:0] irq_mode = ctrl[PPS_CTRL_IRQ +: 2];
    // master modes leave the slave buffers alone
    wire slave_mode = (mode == PPS_MODE_LEGACY) | (mode == PPS_MODE_ENH); // RULE_16
    wire auto_inc   = (mode == PPS_MODE_LEGACY) & (inc_mode == PPS_INC_AUTO); // RULE_18
    // pad left as general i/o means the port never sees a select
    wire cs_ok      = pin_en[PPS_PIN_CS] & ext_cs & slave_mode; // RULE_01
    wire [1:0] alow = port_addr_low & pin_en[1:0]; // RULE_03
    wire ext_wr_go  = cs_ok & ext_wr & ~wr_q;
    wire ext_rd_go  = cs_ok & ext_rd & ~rd_q;
    wire [1:0] wr_slot = slot_sel(mode, auto_inc, alow, wr_ptr); // RULE_11
    wire [1:0] rd_slot = slot_sel(mode, auto_inc, alow, rd_ptr); // RULE_11

    // ---------------------------------------------------------------
    // flag updates; hardware set wins over a same-cycle clear
    // ---------------------------------------------------------------
    wire [3:0] in_set  = slot_hot(wr_slot) & {4{ext_wr_go}} & ~in_full; // RULE_06
    wire       ovf_set = ext_wr_go & in_full[wr_slot]; // RULE_05
    wire [3:0] in_clr  = {{2{apb_rd & hit_in2}}, {2{apb_rd & hit_in1}}}; // RULE_06
    wire [3:0] out_set = slot_hot(rd_slot) & {4{ext_rd_go}} & ~out_empty; // RULE_09
    wire       unf_set = ext_rd_go & out_empty[rd_slot]; // RULE_08
    wire [3:0] out_clr = {pstrb[1:0] & {2{apb_wr & hit_out2}},
                          pstrb[1:0] & {2{apb_wr & hit_out1}}}; // RULE_09
    // only a zero written into the flag clears it
    wire ovf_clr = apb_wr & hit_st & pstrb[1] & ~pwdata[PPS_ST_IN_OVF];
    wire unf_clr = apb_wr & hit_st & pstrb[0] & ~pwdata[PPS_ST_OUT_UNF];
    wire [3:0] next_in_full   = in_set | (in_full & ~in_clr);
    wire [3:0] next_out_empty = out_set | (out_empty & ~out_clr);
    wire next_in_ovf  = ovf_set | (in_ovf & ~ovf_clr); // RULE_05
    wire next_out_unf = unf_set | (out_unf & ~unf_clr); // RULE_08

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    wire in_all_full   = &in_full; // RULE_04
    wire out_all_empty = &out_empty; // RULE_07
    // unimplemented status bits are hard zeros
    wire [15:0] status_word = {in_all_full, in_ovf, 2'h0, in_full,
                               out_all_empty, out_unf, 2'h0, out_empty}; // RULE_15
    wire [15:0] rd_word =
        hit_pin  ? pin_en :
        hit_st   ? status_word :
        hit_pad  ? pad_cfg :
        hit_ctrl ? ctrl :
        hit_in1  ? {in_buf[1], in_buf[0]} :
        hit_in2  ? {in_buf[3], in_buf[2]} :
        hit_out1 ? {out_buf[1], out_buf[0]} :
        hit_out2 ? {out_buf[3], out_buf[2]} : 16'h0000;

    wire buf3_hit  = ((ext_wr_go & (wr_slot == PPS_SLOT_LAST)) |
                      (ext_rd_go & (rd_slot == PPS_SLOT_LAST)));
    wire next_irq  = (irq_mode == PPS_IRQ_BUF3) & buf3_hit; // RULE_17
    wire next_cal  = calendar_out_enable &
                     (pad_cfg[PPS_PAD_SEC] ? seconds_clock : alarm_pulse); // RULE_13

    // ---------------------------------------------------------------
    // apb answer: one wait cycle, then pready with registered data
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc & ~mapped;
            prdata  <= (apb_acc & ~pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // software-written configuration
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_en  <= PPS_REG_RESET;
            pad_cfg <= PPS_REG_RESET;
            ctrl    <= PPS_REG_RESET;
        end else begin
            if (apb_wr & hit_pin) begin
                pin_en <= wr16(pin_en, pwdata, pstrb, PPS_PIN_EN_MASK); // RULE_15
            end
            if (apb_wr & hit_pad) begin
                pad_cfg <= wr16(pad_cfg, pwdata, pstrb, PPS_PADCFG_MASK); // RULE_15
            end
            if (apb_wr & hit_ctrl) begin
                ctrl <= wr16(ctrl, pwdata, pstrb, PPS_CTRL_MASK);
            end
        end
    end

    // ---------------------------------------------------------------
    // status flags and transfer pointers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_full   <= 4'h0;
            out_empty <= PPS_EMPTY_RESET; // RULE_10
            in_ovf    <= 1'b0;
            out_unf   <= 1'b0;
            rd_ptr    <= 2'h0;
            wr_ptr    <= 2'h0;
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
        end else begin
            in_full   <= next_in_full;
            out_empty <= next_out_empty;
            in_ovf    <= next_in_ovf;
            out_unf   <= next_out_unf;
            rd_q      <= ext_rd;
            wr_q      <= ext_wr;
            // pointer walks even on a refused byte, as the master counts it
            if (ext_wr_go & auto_inc) begin
                wr_ptr <= wr_ptr + 2'h1; // RULE_18
            end
            if (ext_rd_go & auto_inc) begin
                rd_ptr <= rd_ptr + 2'h1; // RULE_18
            end
        end
    end

    // ---------------------------------------------------------------
    // byte buffers; a full input byte is never overwritten
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                in_buf[i]  <= 8'h00;
                out_buf[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (in_set[i]) begin
                    in_buf[i] <= ext_din; // RULE_20
                end
                if (out_clr[i]) begin
                    out_buf[i] <= pwdata[8*(i%2) +: 8];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // pad side outputs
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_dout     <= 8'h00;
            ext_dout_oe  <= 1'b0;
            buffer_irq   <= 1'b0;
            calendar_pad <= 1'b0;
        end else begin
            if (ext_rd_go) begin
                ext_dout <= out_buf[rd_slot];
            end
            ext_dout_oe  <= cs_ok & ext_rd;
            buffer_irq   <= next_irq;
            calendar_pad <= next_cal;
        end
    end

    // pin function enables straight from their register bits
    assign chip_select_pin_enable   = pin_en[PPS_PIN_CS]; // RULE_01
    // without upper pads the bits are stored but steer nothing
    assign address_pin_enables      = pin_en[PPS_PIN_ADDR +: 9] &
                                      {9{HAS_UPPER_ADDR}}; // RULE_02 RULE_14
    assign latch_strobe_pin_enables = pin_en[1:0]; // RULE_03
    assign ttl_input_select         = pad_cfg[PPS_PAD_TTL]; // RULE_12

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    all_full_flag_a: assert property ( // RULE_04
        status_word[PPS_ST_IN_ALL] == (in_full == 4'hF))
        else $error("input all-full flag wrong");

    ovf_set_a: assert property ( // RULE_05
        ext_wr_go && in_full[wr_slot] |=> in_ovf)
        else $error("overflow not set");

    ovf_sticky_a: assert property ( // RULE_05
        in_ovf && !ovf_clr |=> in_ovf)
        else $error("overflow dropped without clear");

    ovf_keep_data_a: assert property ( // RULE_20
        ext_wr_go && in_full[wr_slot] |=> in_buf[$past(wr_slot)] == $past(in_buf[wr_slot]))
        else $error("full input byte overwritten");

    in_read_clear_a: assert property ( // RULE_06
        apb_rd && hit_in1 && !ext_wr_go |=> in_full[1:0] == 2'h0)
        else $error("input flags not cleared by read");

    unf_set_a: assert property ( // RULE_08
        ext_rd_go && out_empty[rd_slot] |=> out_unf)
        else $error("underflow not set");

    out_write_clear_a: assert property ( // RULE_09
        apb_wr && hit_out2 && pstrb[0] && !ext_rd_go |=> !out_empty[2])
        else $error("output empty not cleared by write");

    all_empty_flag_a: assert property ( // RULE_07
        status_word[PPS_ST_OUT_ALL] == (out_empty == 4'hF))
        else $error("output all-empty flag wrong");

    reserved_zero_a: assert property ( // RULE_15
        pin_en[13:11] == 3'h0 && pad_cfg[15:2] == 14'h0)
        else $error("unimplemented bits nonzero");

    enh_slot_a: assert property ( // RULE_11
        ext_wr_go && mode == PPS_MODE_ENH && !in_full[alow] |=> in_full[$past(alow)])
        else $error("addressed write missed its slot");

    irq_pulse_a: assert property ( // RULE_17
        irq_mode == PPS_IRQ_BUF3 && ext_rd_go && rd_slot == PPS_SLOT_LAST
        |=> buffer_irq ##1 (!buffer_irq || $past(next_irq)))
        else $error("buffer interrupt not pulsed");

    auto_inc_a: assert property ( // RULE_18
        ext_wr_go && auto_inc |=> wr_ptr == $past(wr_ptr) + 2'h1)
        else $error("write pointer did not advance");

    apb_wait_a: assert property (
        apb_acc |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    fill_all_c: cover property (in_full == 4'hF ##1 in_ovf);
    drain_c:    cover property (ext_rd_go && out_empty[rd_slot]);
    irq_c:      cover property (buffer_irq);
    walk_c:     cover property (auto_inc && ext_wr_go && wr_ptr == PPS_SLOT_LAST);

endmodule

`default_nettype wire

// File: dv/pps_ext_master.sv
// behavioural external bus master driving the slave port pins
`timescale 1ns/10ps
`default_nettype none

module pps_ext_master (
    input  wire logic       pclk,
    input  wire logic [7:0] ext_dout,
    output logic            ext_cs,
    output logic            ext_rd,
    output logic            ext_wr,
    output logic [1:0]      port_addr_low,
    output logic [7:0]      ext_din
);
    // idle: deselected, strobes low
    initial begin
        ext_cs = 1'b0;
        ext_rd = 1'b0;
        ext_wr = 1'b0;
        port_addr_low = 2'h0;
        ext_din = 8'h00;
    end

    // one byte transfer; status is not polled, so over or underflow happens
    // only where the bench asks for it on purpose
    task automatic xfer(input logic rd, input logic [1:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge pclk);
        ext_cs <= 1'b1;
        ext_rd <= rd;
        ext_wr <= ~rd;
        port_addr_low <= a;
        ext_din <= d;
        @(posedge pclk);
        @(posedge pclk);
        q = ext_dout;
        ext_cs <= 1'b0;
        ext_rd <= 1'b0;
        ext_wr <= 1'b0;
        port_addr_low <= ~a; // released lines show no stale value
        ext_din <= ~d;
        @(posedge pclk); // strobe stays low a full clock between transfers
    endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking testbench for the parallel slave port block
`timescale 1ns/10ps
`default_nettype none

module tb;
    import pps_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, ext_din, ext_dout, bq;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0]  pstrb;
    logic [1:0]  port_addr_low, latch_strobe_pin_enables;
    logic [8:0]  address_pin_enables;
    logic        ext_cs, ext_rd, ext_wr, ext_dout_oe, buffer_irq, err_q;
    logic        seconds_clock, alarm_pulse, calendar_out_enable, calendar_pad;
    logic        ttl_input_select, chip_select_pin_enable;
    int          err_count, comparisons, irq_count, oe_count;
    logic [8:0]  upper_en_28;

    pps_slave_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .ext_cs, .ext_rd, .ext_wr, .port_addr_low,
        .ext_din, .ext_dout, .ext_dout_oe, .buffer_irq, .seconds_clock, .alarm_pulse,
        .calendar_out_enable, .calendar_pad, .ttl_input_select, .chip_select_pin_enable,
        .address_pin_enables, .latch_strobe_pin_enables);

    // small package variant shares every input; only its address enables are watched
    pps_slave_port #(.HAS_UPPER_ADDR(1'b0)) dut_28 (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata(), .pready(), .pslverr(), .ext_cs,
        .ext_rd, .ext_wr, .port_addr_low, .ext_din, .ext_dout(), .ext_dout_oe(),
        .buffer_irq(), .seconds_clock, .alarm_pulse, .calendar_out_enable,
        .calendar_pad(), .ttl_input_select(), .chip_select_pin_enable(),
        .address_pin_enables(upper_en_28), .latch_strobe_pin_enables());

    pps_ext_master host (.pclk, .ext_dout, .ext_cs, .ext_rd, .ext_wr, .port_addr_low,
        .ext_din);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // irq pulses are one cycle wide, so count them as they pass
    always @(posedge pclk) begin
        if (buffer_irq === 1'b1) begin
            irq_count++;
        end
        if (ext_dout_oe === 1'b1) begin
            oe_count++;
        end
    end

    // ---------------------------------------------------------------
    // checking and apb tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) begin
            @(posedge pclk);
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_count++;
            $display("unexpected at %0t: no pready", $time);
            complete_run();
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask

    // calendar pad is registered, so look two edges after the change
    task automatic cal(input logic en, input logic sec, input logic alm, input logic exp);
        @(posedge pclk);
        calendar_out_enable <= en;
        seconds_clock <= sec;
        alarm_pulse <= alm;
        repeat (2) @(posedge pclk);
        chk(32'(calendar_pad), 32'(exp));
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        int i;
        err_count = 0;
        comparisons = 0;
        irq_count = 0;
        oe_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        {seconds_clock, alarm_pulse, calendar_out_enable} = 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(PPS_OFF_STATUS, 32'h0000_008F);
        rdchk(PPS_OFF_PIN_EN, 32'h0000_0000);
        host.xfer(1'b0, 2'h0, 8'h55, bq); // chip select pad not enabled yet
        rdchk(PPS_OFF_STATUS, 32'h0000_008F);
        apb(1'b1, PPS_OFF_PIN_EN, 32'hFFFF_FFFF);
        rdchk(PPS_OFF_PIN_EN, 32'h0000_47FF);
        chk(32'({chip_select_pin_enable, address_pin_enables, latch_strobe_pin_enables}), 32'hFFF);
        chk(32'(upper_en_28), 32'h0);
        apb(1'b1, PPS_OFF_PIN_EN, 32'h0000_4001);
        @(negedge pclk); // register bits land at the edge that ends the write
        chk(32'({chip_select_pin_enable, address_pin_enables, latch_strobe_pin_enables}), 32'h801);
        apb(1'b1, PPS_OFF_PADCFG, 32'hFFFF_FFFF);
        rdchk(PPS_OFF_PADCFG, 32'h0000_0003);
        chk(32'(ttl_input_select), 32'h1);
        cal(1'b1, 1'b1, 1'b0, 1'b1);
        cal(1'b0, 1'b1, 1'b0, 1'b0);
        apb(1'b1, PPS_OFF_PADCFG, 32'h0);
        @(negedge pclk);
        chk(32'(ttl_input_select), 32'h0);
        cal(1'b1, 1'b1, 1'b0, 1'b0);
        cal(1'b1, 1'b0, 1'b1, 1'b1);
        apb(1'b0, 8'h40, 32'h0); // unmapped address is refused
        chk({31'h0, err_q}, 32'h1);
        chk(rd_q, 32'h0);
        // enhanced addressed mode with buffer-3 interrupt
        apb(1'b1, PPS_OFF_PIN_EN, 32'h0000_4003);
        apb(1'b1, PPS_OFF_CTRL, 32'h0000_6100);
        for (i = 0; i < 4; i++) begin
            host.xfer(1'b0, i[1:0], 8'(i) + 8'h10, bq);
        end
        chk(32'(irq_count), 32'h1);
        rdchk(PPS_OFF_STATUS, 32'h0000_8F8F);
        rdchk(PPS_OFF_IN1, 32'h0000_1110);
        rdchk(PPS_OFF_STATUS, 32'h0000_0C8F);
        host.xfer(1'b0, 2'h2, 8'hAA, bq); // write into a full byte on purpose
        rdchk(PPS_OFF_STATUS, 32'h0000_4C8F);
        rdchk(PPS_OFF_IN2, 32'h0000_1312);
        apb(1'b1, PPS_OFF_STATUS, 32'h0);
        rdchk(PPS_OFF_STATUS, 32'h0000_008F);
        host.xfer(1'b1, 2'h1, 8'h00, bq); // read from an empty byte on purpose
        rdchk(PPS_OFF_STATUS, 32'h0000_00CF);
        apb(1'b1, PPS_OFF_STATUS, 32'h0);
        apb(1'b1, PPS_OFF_OUT2, 32'h0000_BEEF);
        rdchk(PPS_OFF_STATUS, 32'h0000_0003);
        host.xfer(1'b1, 2'h3, 8'h00, bq);
        chk(32'(bq), 32'hBE);
        rdchk(PPS_OFF_STATUS, 32'h0000_000B);
        host.xfer(1'b1, 2'h2, 8'h00, bq);
        chk(32'(bq), 32'hEF);
        rdchk(PPS_OFF_STATUS, 32'h0000_008F);
        chk(32'(irq_count), 32'h2);
        // legacy mode walks the buffers and ignores the address lines
        apb(1'b1, PPS_OFF_CTRL, 32'h0000_1800);
        host.xfer(1'b0, 2'h3, 8'h21, bq);
        host.xfer(1'b0, 2'h3, 8'h22, bq);
        rdchk(PPS_OFF_IN1, 32'h0000_2221);
        // three enabled reads, data lines driven for two clocks each
        chk(32'(oe_count), 32'h6);
        complete_run();
    end
endmodule
`default_nettype wire
